// [core/gpio_exp_map.svh]
// Register indices, reset values and address constants of the IO expander
`ifndef GPIO_EXP_MAP_SVH
`define GPIO_EXP_MAP_SVH
`define GPIO_EXP_IDX_IN0     3'h0
`define GPIO_EXP_IDX_IN1     3'h1
`define GPIO_EXP_IDX_OUT0    3'h2
`define GPIO_EXP_IDX_OUT1    3'h3
`define GPIO_EXP_IDX_POL0    3'h4
`define GPIO_EXP_IDX_POL1    3'h5
`define GPIO_EXP_IDX_DIR0    3'h6
`define GPIO_EXP_IDX_DIR1    3'h7
`define GPIO_EXP_OUT_RST     16'hFFFF
`define GPIO_EXP_POL_RST     16'h0000
`define GPIO_EXP_DIR_RST     16'hFFFF
`define GPIO_EXP_ADDR_BASE   4'h4
`define GPIO_EXP_BYTE_BITS   4'h8
`endif

// [core/gpio_exp_pkg.sv]
// Types shared by the IO expander modules
package gpio_exp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_A,
    ST_WRITE,
    ST_ACK_W,
    ST_READ,
    ST_ACK_R
  } i2c_state_t;
  typedef logic [7:0] byte_t;
endpackage : gpio_exp_pkg

// [core/i2c_reg_if.sv]
// Byte path between the serial target and the register file
`timescale 1ns/100ps
interface i2c_reg_if;
  logic                 wr_stb;
  logic                 wr_first;
  gpio_exp_pkg::byte_t  wr_data;
  logic                 rd_req;
  gpio_exp_pkg::byte_t  rd_data;
  modport target (output wr_stb, output wr_first, output wr_data, output rd_req, input rd_data);
  modport regs   (input wr_stb, input wr_first, input wr_data, input rd_req, output rd_data);
endinterface : i2c_reg_if

// [core/i2c_target.sv]
// Serial bus target: bit timing, address match, acknowledge and byte transfer
`timescale 1ns/100ps
`include "gpio_exp_map.svh"
module i2c_target (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Synchronised bus lines and address
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic [6:0]  dev_addr_i,
  // Data line pull-down
  output logic             sda_low_o,
  // Byte path
  i2c_reg_if.target        rif
);
  gpio_exp_pkg::i2c_state_t st_r;
  logic                     scl_q_r;
  logic                     sda_q_r;
  logic [3:0]               cnt_r;
  gpio_exp_pkg::byte_t      sh_r;
  gpio_exp_pkg::byte_t      tx_r;
  logic                     rw_r;
  logic                     nack_r;
  logic                     first_r;
  logic                     rise;
  logic                     fall;
  logic                     start;
  logic                     stop;

  assign rise  = scl_i & ~scl_q_r;
  assign fall  = ~scl_i & scl_q_r;
  assign start = scl_i & scl_q_r & sda_q_r & ~sda_i;
  assign stop  = scl_i & scl_q_r & ~sda_q_r & sda_i;
  // Next byte is fetched on the edge that starts a read byte
  assign rif.rd_req = fall & rw_r & ((st_r == gpio_exp_pkg::ST_ACK_A) |
                      ((st_r == gpio_exp_pkg::ST_ACK_R) & ~nack_r));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r        <= gpio_exp_pkg::ST_IDLE;
      cnt_r       <= 4'h0;
      sh_r        <= 8'h00;
      tx_r        <= 8'h00;
      rw_r        <= 1'b0;
      nack_r      <= 1'b0;
      first_r     <= 1'b0;
      sda_low_o   <= 1'b0;
      rif.wr_stb  <= 1'b0;
      rif.wr_first<= 1'b0;
      rif.wr_data <= 8'h00;
    end else begin
      rif.wr_stb <= 1'b0;
      if (start) begin
        st_r      <= gpio_exp_pkg::ST_ADDR;
        cnt_r     <= 4'h0;
        sda_low_o <= 1'b0;
      end else if (stop) begin
        st_r      <= gpio_exp_pkg::ST_IDLE;
        sda_low_o <= 1'b0;
      end else begin
        case (st_r)
          gpio_exp_pkg::ST_ADDR, gpio_exp_pkg::ST_WRITE: begin
            if (rise) begin
              sh_r  <= {sh_r[6:0], sda_i};
              cnt_r <= cnt_r + 4'h1;
            end else if (fall && cnt_r == `GPIO_EXP_BYTE_BITS) begin
              cnt_r <= 4'h0;
              if (st_r == gpio_exp_pkg::ST_WRITE) begin
                rif.wr_stb   <= 1'b1;
                rif.wr_first <= first_r;
                rif.wr_data  <= sh_r;
                first_r      <= 1'b0;
                sda_low_o    <= 1'b1;
                st_r         <= gpio_exp_pkg::ST_ACK_W;
              end else if (sh_r[7:1] == dev_addr_i) begin // see [RQ14] [RQ11]
                rw_r      <= sh_r[0];
                first_r   <= ~sh_r[0];
                sda_low_o <= 1'b1;
                st_r      <= gpio_exp_pkg::ST_ACK_A;
              end else begin
                st_r <= gpio_exp_pkg::ST_IDLE;
              end
            end
          end
          gpio_exp_pkg::ST_ACK_A, gpio_exp_pkg::ST_ACK_W, gpio_exp_pkg::ST_ACK_R: begin
            if (rise && st_r == gpio_exp_pkg::ST_ACK_R) begin
              nack_r <= sda_i;
            end else if (fall) begin
              if (rif.rd_req) begin
                tx_r      <= {rif.rd_data[6:0], 1'b0};
                sda_low_o <= ~rif.rd_data[7];
                cnt_r     <= 4'h1;
                st_r      <= gpio_exp_pkg::ST_READ;
              end else begin
                sda_low_o <= 1'b0;
                st_r      <= (rw_r || st_r == gpio_exp_pkg::ST_ACK_R) ?
                             gpio_exp_pkg::ST_IDLE : gpio_exp_pkg::ST_WRITE;
              end
            end
          end
          gpio_exp_pkg::ST_READ: begin
            if (fall) begin
              if (cnt_r == `GPIO_EXP_BYTE_BITS) begin
                sda_low_o <= 1'b0;
                cnt_r     <= 4'h0;
                st_r      <= gpio_exp_pkg::ST_ACK_R;
              end else begin
                sda_low_o <= ~tx_r[7];
                tx_r      <= {tx_r[6:0], 1'b0};
                cnt_r     <= cnt_r + 4'h1;
              end
            end
          end
          default: begin
            sda_low_o <= 1'b0;
          end
        endcase
      end
    end
  end

  property p_ack_only_own_addr;
    @(posedge clk_i) disable iff (!rst_b_i)
      (st_r == gpio_exp_pkg::ST_ADDR) ##1 (st_r == gpio_exp_pkg::ST_ACK_A)
      |-> ($past(sh_r[7:1]) == dev_addr_i) && sda_low_o;
  endproperty
  a_ack_only_own_addr: assert property (p_ack_only_own_addr) // see [RQ14]
    else $error("acknowledged a foreign address");
endmodule : i2c_target

// [core/gpio_expander.sv]
// Sixteen-pin IO expander: pin logic, registers, change interrupt, bus target
//
// Behaviour
// [RQ1] Sixteen pins, each input or output independently
// [RQ2] All pins inputs after power-up
// [RQ3] Direction and polarity change only by bus writes
// [RQ4] Polarity bit flips reported input value
// [RQ5] Input pins sampled continuously for changes
// [RQ6] Input change asserts the interrupt output
// [RQ7] Reading input state releases the interrupt
// [RQ8] Interrupt is active-low open-drain
// [RQ9] Output pins driven push-pull
// [RQ10] Hardware reset low restores register defaults
// [RQ11] Address pins pick one of eight addresses
// [RQ12] Power-on reset holds logic in defaults
// [RQ13] Output level from output register; inputs reflect pins
// [RQ14] Bus target answers own address, host clock
`timescale 1ns/100ps
`include "gpio_exp_map.svh"
module gpio_expander (
  // Clock and power-on reset
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  // Hardware reset pin
  input  wire logic        HW_RESET_N_I,
  // Address select pins
  input  wire logic        ADDR_SEL_0_I,
  input  wire logic        ADDR_SEL_1_I,
  input  wire logic        ADDR_SEL_2_I,
  // Serial bus
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  // Interrupt, open-drain
  output logic             IRQ_OUT_N_O,
  output logic             IRQ_OUT_N_OE_O,
  // General-purpose pins
  input  wire logic [7:0]  PORT0_PINS_I,
  output logic      [7:0]  PORT0_PINS_O,
  output logic      [7:0]  PORT0_PINS_OE_O,
  input  wire logic [7:0]  PORT1_PINS_I,
  output logic      [7:0]  PORT1_PINS_O,
  output logic      [7:0]  PORT1_PINS_OE_O
);
  i2c_reg_if   rif ();
  logic [15:0] pin_m_r;
  logic [15:0] pin_s_r;
  logic [15:0] prev_r;
  logic [1:0]  fill_r;
  logic [1:0]  bus_m_r;
  logic [1:0]  bus_s_r;
  logic [3:0]  ctl_m_r;
  logic [3:0]  ctl_s_r;
  logic [15:0] out_r;
  logic [15:0] pol_r;
  logic [15:0] dir_r;
  logic [2:0]  ptr_r;
  logic        irq_r;
  logic        sda_low;
  logic        sw_rst;
  logic        irq_set;
  logic        irq_clr;
  logic [15:0] in_view;

  function automatic gpio_exp_pkg::byte_t pick(input logic [15:0] v, input logic hi);
    pick = hi ? v[15:8] : v[7:0];
  endfunction : pick

  function automatic logic [15:0] put(input logic [15:0] v, input logic hi,
                                      input gpio_exp_pkg::byte_t b);
    put = hi ? {b, v[7:0]} : {v[15:8], b};
  endfunction : put

  // Two-stage synchronisers for every pin that comes from outside, except the clock and the power-on reset
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pin_m_r <= 16'h0000;
      pin_s_r <= 16'h0000;
      bus_m_r <= 2'h3;
      bus_s_r <= 2'h3;
      ctl_m_r <= 4'h0;
      ctl_s_r <= 4'h0;
    end else begin
      pin_m_r <= {PORT1_PINS_I, PORT0_PINS_I};
      pin_s_r <= pin_m_r;
      bus_m_r <= {SCL_I, SDA_I};
      bus_s_r <= bus_m_r;
      ctl_m_r <= {HW_RESET_N_I, ADDR_SEL_2_I, ADDR_SEL_1_I, ADDR_SEL_0_I};
      ctl_s_r <= ctl_m_r;
    end
  end

  assign sw_rst  = ~ctl_s_r[3];
  assign in_view = pin_s_r ^ pol_r;                                        // see [RQ4] [RQ13]

  i2c_target u_target (
    .clk_i      (CLK_I),
    .rst_b_i    (RST_B_I),
    .scl_i      (bus_s_r[1]),
    .sda_i      (bus_s_r[0]),
    .dev_addr_i ({`GPIO_EXP_ADDR_BASE, ctl_s_r[2:0]}),                     // see [RQ11]
    .sda_low_o  (sda_low),
    .rif        (rif.target)
  );

  always_comb begin
    case (ptr_r[2:1])
      2'h0:    rif.rd_data = pick(in_view, ptr_r[0]);
      2'h1:    rif.rd_data = pick(out_r, ptr_r[0]);
      2'h2:    rif.rd_data = pick(pol_r, ptr_r[0]);
      default: rif.rd_data = pick(dir_r, ptr_r[0]);
    endcase
  end

  // Registers: power-on and hardware reset both restore defaults
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin                                                    // see [RQ12]
      out_r <= `GPIO_EXP_OUT_RST;
      pol_r <= `GPIO_EXP_POL_RST;
      dir_r <= `GPIO_EXP_DIR_RST;                                          // see [RQ2]
      ptr_r <= 3'h0;
    end else if (sw_rst) begin                                             // see [RQ10]
      out_r <= `GPIO_EXP_OUT_RST;
      pol_r <= `GPIO_EXP_POL_RST;
      dir_r <= `GPIO_EXP_DIR_RST;
      ptr_r <= 3'h0;
    end else if (rif.wr_stb && rif.wr_first) begin
      ptr_r <= rif.wr_data[2:0];
    end else if (rif.wr_stb) begin                                         // see [RQ3]
      case (ptr_r[2:1])
        2'h1:    out_r <= put(out_r, ptr_r[0], rif.wr_data);
        2'h2:    pol_r <= put(pol_r, ptr_r[0], rif.wr_data);
        2'h3:    dir_r <= put(dir_r, ptr_r[0], rif.wr_data);
        default: out_r <= out_r;
      endcase
      ptr_r <= ptr_r ^ 3'h1;
    end else if (rif.rd_req) begin
      ptr_r <= ptr_r ^ 3'h1;
    end
  end

  // Change detection on input pins; a new change wins over a read
  // Held off after reset until the synchronisers and last sample hold real pin levels
  assign irq_set = (fill_r == 2'h3) && |((pin_s_r ^ prev_r) & dir_r);      // see [RQ5]
  assign irq_clr = rif.rd_req && (ptr_r[2:1] == 2'h0);                     // see [RQ7]

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      prev_r <= 16'h0000;
      fill_r <= 2'h0;
      irq_r  <= 1'b0;
    end else begin
      prev_r <= pin_s_r;
      if (fill_r != 2'h3) begin
        fill_r <= fill_r + 2'h1;
      end
      if (sw_rst) begin
        irq_r <= 1'b0;
      end else if (irq_set) begin                                          // see [RQ6]
        irq_r <= 1'b1;
      end else if (irq_clr) begin
        irq_r <= 1'b0;
      end
    end
  end

  assign IRQ_OUT_N_O     = 1'b0;                                           // see [RQ8]
  assign IRQ_OUT_N_OE_O  = irq_r;
  assign SDA_O           = 1'b0;
  assign SDA_OE_O        = sda_low;
  assign PORT0_PINS_O    = out_r[7:0];                                     // see [RQ9] [RQ13]
  assign PORT1_PINS_O    = out_r[15:8];
  assign PORT0_PINS_OE_O = ~dir_r[7:0];                                    // see [RQ1]
  assign PORT1_PINS_OE_O = ~dir_r[15:8];

  property p_por_inputs;
    @(posedge CLK_I) $rose(RST_B_I) |-> dir_r == `GPIO_EXP_DIR_RST && !IRQ_OUT_N_OE_O;
  endproperty
  a_por_inputs: assert property (p_por_inputs) // see [RQ2] [RQ12]
    else $error("pins not all inputs after power-on");

  property p_hw_reset;
    @(posedge CLK_I) disable iff (!RST_B_I)
      sw_rst |=> PORT0_PINS_OE_O == 8'h00 && PORT1_PINS_OE_O == 8'h00 && pol_r == 16'h0000;
  endproperty
  a_hw_reset: assert property (p_hw_reset) // see [RQ10]
    else $error("hardware reset did not restore defaults");

  property p_dir_write;
    @(posedge CLK_I) disable iff (!RST_B_I)
      rif.wr_stb && !rif.wr_first && !sw_rst && ptr_r == `GPIO_EXP_IDX_DIR0
      |=> PORT0_PINS_OE_O == ~$past(rif.wr_data);
  endproperty
  a_dir_write: assert property (p_dir_write) // see [RQ1] [RQ3]
    else $error("direction write not applied");

  property p_dir_only_by_write;
    @(posedge CLK_I) disable iff (!RST_B_I)
      !rif.wr_stb && !sw_rst |=> $stable(dir_r) && $stable(pol_r);
  endproperty
  a_dir_only_by_write: assert property (p_dir_only_by_write) // see [RQ3]
    else $error("configuration changed without a write");

  property p_polarity_read;
    @(posedge CLK_I) disable iff (!RST_B_I)
      rif.rd_req && ptr_r == `GPIO_EXP_IDX_IN1 |-> rif.rd_data == (pin_s_r[15:8] ^ pol_r[15:8]);
  endproperty
  a_polarity_read: assert property (p_polarity_read) // see [RQ4] [RQ13]
    else $error("input read does not match pins after inversion");

  property p_change_irq;
    @(posedge CLK_I) disable iff (!RST_B_I)
      fill_r == 2'h3 && ((pin_s_r ^ prev_r) & dir_r) != 16'h0000 && !sw_rst
      |=> IRQ_OUT_N_OE_O;
  endproperty
  a_change_irq: assert property (p_change_irq) // see [RQ5] [RQ6]
    else $error("input change did not raise the interrupt");

  property p_read_clears;
    @(posedge CLK_I) disable iff (!RST_B_I)
      rif.rd_req && (ptr_r == `GPIO_EXP_IDX_IN0 || ptr_r == `GPIO_EXP_IDX_IN1) && !irq_set
      |=> !IRQ_OUT_N_OE_O;
  endproperty
  a_read_clears: assert property (p_read_clears) // see [RQ7]
    else $error("input read did not release the interrupt");

  property p_irq_holds;
    @(posedge CLK_I) disable iff (!RST_B_I)
      IRQ_OUT_N_OE_O && !irq_clr && !sw_rst |=> IRQ_OUT_N_OE_O && IRQ_OUT_N_O == 1'b0;
  endproperty
  a_irq_holds: assert property (p_irq_holds) // see [RQ8]
    else $error("interrupt released without an input read");

  property p_output_drive;
    @(posedge CLK_I) disable iff (!RST_B_I)
      rif.wr_stb && !rif.wr_first && !sw_rst && ptr_r == `GPIO_EXP_IDX_OUT0
      |=> PORT0_PINS_O == $past(rif.wr_data);
  endproperty
  a_output_drive: assert property (p_output_drive) // see [RQ9] [RQ13]
    else $error("output value write not driven");

  c_irq_then_read: cover property (@(posedge CLK_I) disable iff (!RST_B_I)
    IRQ_OUT_N_OE_O ##[1:1000] !IRQ_OUT_N_OE_O);
  c_dir_write: cover property (@(posedge CLK_I) disable iff (!RST_B_I)
    rif.wr_stb && !rif.wr_first && ptr_r == `GPIO_EXP_IDX_DIR1);
  c_hw_reset: cover property (@(posedge CLK_I) disable iff (!RST_B_I) $rose(sw_rst));
  c_read_byte: cover property (@(posedge CLK_I) disable iff (!RST_B_I) rif.rd_req);
endmodule : gpio_expander

// [tb/i2c_host_model.sv]
// Serial bus host model that drives clock and data toward the expander
`timescale 1ns/100ps
module i2c_host_model (
  // Clock
  input  wire logic clk_i,
  // Device pull-down on the data wire
  input  wire logic sda_oe_i,
  input  wire logic sda_dv_i,
  // Bus wires as the device sees them
  output logic      scl_o,
  output logic      sda_o
);
  logic scl_r;
  logic sda_low_r;

  // Wired-and data line with pull-up: a released line reads high
  assign sda_o = ~sda_low_r & (sda_oe_i ? sda_dv_i : 1'b1);
  assign scl_o = scl_r;

  initial begin
    scl_r     = 1'b1;
    sda_low_r = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_clk

  // One bit slot of 16 clocks; the wire is sampled in mid high phase
  task automatic bit_slot(input logic b, output logic r);
    scl_r <= 1'b0;
    wait_clk(4);
    sda_low_r <= ~b;
    wait_clk(4);
    scl_r <= 1'b1;
    wait_clk(4);
    r = sda_o;
    wait_clk(4);
  endtask : bit_slot

  // Also serves as repeated start after an acknowledge
  task automatic start();
    scl_r <= 1'b0;
    wait_clk(4);
    sda_low_r <= 1'b0;
    wait_clk(4);
    scl_r <= 1'b1;
    wait_clk(8);
    sda_low_r <= 1'b1;
    wait_clk(8);
  endtask : start

  task automatic stop();
    scl_r <= 1'b0;
    wait_clk(4);
    sda_low_r <= 1'b1;
    wait_clk(4);
    scl_r <= 1'b1;
    wait_clk(8);
    sda_low_r <= 1'b0;
    wait_clk(8);
  endtask : stop

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], r);
    end
    bit_slot(1'b1, r);
    ack = ~r;
  endtask : write_byte

  // Reading the input state is how the host clears the interrupt
  task automatic read_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, d[i]);
    end
    bit_slot(last, r);
  endtask : read_byte
endmodule : i2c_host_model

// [tb/tb_top.sv]
// Self-checking testbench of the sixteen-pin IO expander
`timescale 1ns/100ps
`include "gpio_exp_map.svh"
module tb_top;
  logic        clk;
  logic        rst_b_r;
  logic        hw_rst_n_r;
  logic [2:0]  addr_sel_r;
  logic [15:0] ext_r;
  logic [15:0] pin_w;
  logic [15:0] oe_w;
  logic [15:0] out_w;
  logic        scl_w;
  logic        sda_w;
  logic        sda_o_w;
  logic        sda_oe_w;
  logic        irq_w;
  logic        irq_oe_w;
  logic [7:0]  p0_o;
  logic [7:0]  p1_o;
  logic [7:0]  p0_oe;
  logic [7:0]  p1_oe;
  int          error_cnt;
  int          samples_checked;
  logic [15:0] d;

  assign oe_w  = {p1_oe, p0_oe};
  assign out_w = {p1_o, p0_o};
  // Pins in output mode carry the device level, others the board level
  assign pin_w = (oe_w & out_w) | (~oe_w & ext_r);

  gpio_expander i_gpio_expander (
    .CLK_I(clk), .RST_B_I(rst_b_r), .HW_RESET_N_I(hw_rst_n_r),
    .ADDR_SEL_0_I(addr_sel_r[0]), .ADDR_SEL_1_I(addr_sel_r[1]), .ADDR_SEL_2_I(addr_sel_r[2]),
    .SCL_I(scl_w), .SDA_I(sda_w), .SDA_O(sda_o_w), .SDA_OE_O(sda_oe_w),
    .IRQ_OUT_N_O(irq_w), .IRQ_OUT_N_OE_O(irq_oe_w),
    .PORT0_PINS_I(pin_w[7:0]), .PORT0_PINS_O(p0_o), .PORT0_PINS_OE_O(p0_oe),
    .PORT1_PINS_I(pin_w[15:8]), .PORT1_PINS_O(p1_o), .PORT1_PINS_OE_O(p1_oe)
  );

  i2c_host_model i_i2c_host_model (
    .clk_i(clk), .sda_oe_i(sda_oe_w), .sda_dv_i(sda_o_w), .scl_o(scl_w), .sda_o(sda_w)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic conclude();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  task automatic dev_addr(input logic rw);
    logic ack;
    i_i2c_host_model.start();
    i_i2c_host_model.write_byte({`GPIO_EXP_ADDR_BASE, addr_sel_r, rw}, ack);
    check({15'h0000, ack}, 16'h0001);
  endtask : dev_addr

  task automatic wr_reg(input logic [2:0] idx, input logic [15:0] v);
    logic ack;
    dev_addr(1'b0);
    i_i2c_host_model.write_byte({5'h00, idx}, ack);
    i_i2c_host_model.write_byte(v[7:0], ack);
    i_i2c_host_model.write_byte(v[15:8], ack);
    i_i2c_host_model.stop();
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] idx, output logic [15:0] v);
    logic ack;
    dev_addr(1'b0);
    i_i2c_host_model.write_byte({5'h00, idx}, ack);
    dev_addr(1'b1);
    i_i2c_host_model.read_byte(1'b0, v[7:0]);
    i_i2c_host_model.read_byte(1'b1, v[15:8]);
    i_i2c_host_model.stop();
  endtask : rd_reg

  task automatic t_defaults();
    check(oe_w, 16'h0000);
    check(out_w, `GPIO_EXP_OUT_RST);
    check({14'h0000, irq_w, irq_oe_w}, 16'h0000);
    rd_reg(`GPIO_EXP_IDX_DIR0, d);
    check(d, `GPIO_EXP_DIR_RST);
  endtask : t_defaults

  task automatic t_addr();
    logic ack;
    for (int a = 0; a < 8; a++) begin
      addr_sel_r <= a[2:0];
      wait_clk(4);
      dev_addr(1'b0);
      i_i2c_host_model.stop();
    end
    i_i2c_host_model.start();
    i_i2c_host_model.write_byte({4'h2, addr_sel_r, 1'b0}, ack);
    i_i2c_host_model.stop();
    check({15'h0000, ack}, 16'h0000);
  endtask : t_addr

  task automatic t_dir_out();
    wr_reg(`GPIO_EXP_IDX_OUT0, 16'h3CA5);
    wr_reg(`GPIO_EXP_IDX_DIR0, 16'h0FF0);
    check(oe_w, 16'hF00F);
    check(out_w, 16'h3CA5);
    rd_reg(`GPIO_EXP_IDX_OUT0, d);
    check(d, 16'h3CA5);
    // Writes aimed at the input pair change nothing
    wr_reg(`GPIO_EXP_IDX_IN0, 16'h0000);
    check(out_w, 16'h3CA5);
    check(oe_w, 16'hF00F);
  endtask : t_dir_out

  task automatic t_polarity();
    ext_r <= 16'h5A5A;
    wait_clk(6);
    rd_reg(`GPIO_EXP_IDX_IN0, d);
    check(d, 16'h3A55);
    wr_reg(`GPIO_EXP_IDX_POL0, 16'hFF00);
    rd_reg(`GPIO_EXP_IDX_IN0, d);
    check(d, 16'hC555);
  endtask : t_polarity

  task automatic t_irq();
    check({15'h0000, irq_oe_w}, 16'h0000);
    ext_r <= ext_r ^ 16'h0010;
    wait_clk(6);
    check({14'h0000, irq_w, irq_oe_w}, 16'h0001);
    rd_reg(`GPIO_EXP_IDX_IN0, d);
    check(d, 16'hC545);
    wait_clk(2);
    check({15'h0000, irq_oe_w}, 16'h0000);
    wr_reg(`GPIO_EXP_IDX_OUT0, 16'h3CA4);
    ext_r <= ext_r ^ 16'h0001;
    wait_clk(6);
    check({15'h0000, irq_oe_w}, 16'h0000);
    ext_r <= ext_r ^ 16'h0100;
    wait_clk(6);
    check({15'h0000, irq_oe_w}, 16'h0001);
    rd_reg(`GPIO_EXP_IDX_IN0, d);
    wait_clk(2);
    check({15'h0000, irq_oe_w}, 16'h0000);
  endtask : t_irq

  task automatic t_resets();
    hw_rst_n_r <= 1'b0;
    wait_clk(5);
    hw_rst_n_r <= 1'b1;
    wait_clk(4);
    check(oe_w, 16'h0000);
    check(out_w, `GPIO_EXP_OUT_RST);
    rd_reg(`GPIO_EXP_IDX_POL0, d);
    check(d, `GPIO_EXP_POL_RST);
    wr_reg(`GPIO_EXP_IDX_DIR0, 16'h0000);
    check(oe_w, 16'hFFFF);
    rst_b_r <= 1'b0;
    wait_clk(3);
    check(oe_w, 16'h0000);
    rst_b_r <= 1'b1;
    wait_clk(4);
    check(out_w, `GPIO_EXP_OUT_RST);
    // Pins return to non-zero board levels: no false change after reset
    check({14'h0000, irq_w, irq_oe_w}, 16'h0000);
  endtask : t_resets

  initial begin
    error_cnt       = 0;
    samples_checked = 0;
    rst_b_r         = 1'b0;
    hw_rst_n_r      = 1'b1;
    addr_sel_r      = 3'h5;
    ext_r           = 16'h0000;
    wait_clk(12);
    rst_b_r <= 1'b1;
    wait_clk(4);
    t_defaults();
    t_addr();
    t_dir_out();
    t_polarity();
    t_irq();
    t_resets();
    conclude();
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    wait_clk(90000);
    error_cnt++;
    conclude();
  end
endmodule : tb_top
